// >>> core/drci_pkg.sv
// Constants shared by the row control interface: sizes, row assignments,
// register indices, field positions and write masks.
// Assumes a single 125 MHz clock domain and a word-aligned register port.

package drci_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NROW = 8;
    localparam int NLOC = 30;
    localparam int NDL = 10;
    localparam int WDAT = 18;
    localparam int WHALF = 9;
    localparam int NCLK = 4;
    localparam int NCTL = 6;
    localparam int NHALF = 2;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int IW = 5;

    // ****************************************************************
    // Row on which each control enters (row 1 is index 0)
    // ****************************************************************
    localparam int CLK_ROW [NCLK] = '{2, 3, 4, 5};
    localparam int CLR_ROW [NCLK] = '{0, 3, 4, 6};
    // Order: sign A, sign B, add/sub upper, add/sub lower, zero upper, zero lower
    localparam int CTL_ROW [NCTL] = '{0, 5, 2, 6, 1, 6};
    localparam int CTL_SIGN_A = 0;
    localparam int CTL_SIGN_B = 1;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [5:0] REG_CLK = 6'h00;
    localparam logic [5:0] REG_CLR = 6'h04;
    localparam logic [5:0] REG_ENA = 6'h08;
    localparam logic [5:0] REG_CTL = 6'h0C;
    localparam logic [5:0] REG_ROW = 6'h18;
    localparam logic [5:0] REG_MODE = 6'h20;
    localparam logic [5:0] REG_STATUS = 6'h21;
    localparam int NREG = 33;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int F_IDX = 0;
    localparam int F_SRC = 8;
    localparam int F_REG = 8;
    localparam int F_CKS = 12;
    localparam int F_CRS = 16;
    localparam int F_LO_CKS = 16;
    localparam int F_LO_CRS = 20;
    localparam int F_ROW_REG = 24;
    localparam int F_OUT_REG = 25;
    localparam int F_OUT_CKS = 28;
    localparam int F_OUT_CRS = 30;
    localparam int F_SPLIT = 0;

    // ****************************************************************
    // Write masks and reset value
    // ****************************************************************
    localparam logic [DW-1:0] MASK_CLK = 32'h0000011F;
    localparam logic [DW-1:0] MASK_ENA = 32'h0000001F;
    localparam logic [DW-1:0] MASK_CTL = 32'h0003311F;
    localparam logic [DW-1:0] MASK_ROW = 32'hF333331F;
    localparam logic [DW-1:0] MASK_MODE = 32'h00000001;
    localparam logic [DW-1:0] CFG_RST = 32'h00000000;

endpackage

// >>> core/drci_bank.sv
// One register bank: a group of bits sharing one selected clock and clear.
// Assumes tick and clear are already selected and synchronous to clk_in.

`timescale 1ns/1ps
`default_nettype none

module drci_bank #(
    parameter int W = 9
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [W-1:0] d_in,
    input wire logic tick_in,
    input wire logic clr_in,
    input wire logic bypass_in,
    output logic [W-1:0] q_out
);

    logic [W-1:0] q_q;
    logic [W-1:0] q_d;

    // ****************************************************************
    // Bank register
    // ****************************************************************
    always_comb begin
        if (bypass_in) begin
            q_d = d_in;
        end else if (clr_in) begin
            q_d = '0;
        end else if (tick_in) begin
            q_d = d_in;
        end else begin
            q_d = q_q;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end

    assign q_out = q_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_bank_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!bypass_in && clr_in) |=> (q_out == '0))
        else $error("bank not cleared");
    a_bank_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!bypass_in && !clr_in && !tick_in) |=> $stable(q_out))
        else $error("bank changed without its clock");
    a_bank_load: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!bypass_in && !clr_in && tick_in) |=> (q_out == $past(d_in)))
        else $error("bank missed its load");

endmodule

`default_nettype wire

// >>> core/drci_clkgen.sv
// Bank clock source: picks the row clock or a local line, and gates the
// rising edge with the paired enable into a one-cycle tick.
// Assumes both sources are synchronous levels sampled on clk_in.

`timescale 1ns/1ps
`default_nettype none

module drci_clkgen (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic row_clk_in,
    input wire logic local_in,
    input wire logic src_in,
    input wire logic ena_in,
    output logic level_out,
    output logic tick_out
);

    logic prev_q;
    logic prev_d;

    // ****************************************************************
    // Edge detect with enable at the interface
    // ****************************************************************
    always_comb begin
        level_out = src_in ? row_clk_in : local_in;
        prev_d = level_out;
        tick_out = level_out && !prev_q && ena_in;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            // Start high: a level held through reset must not count as an edge
            prev_q <= 1'b1;
        end else begin
            prev_q <= prev_d;
        end
    end

    a_tick_gated: assert property (@(posedge clk_in) disable iff (!nrst_in)
        tick_out |-> (ena_in && level_out && !$past(level_out)))
        else $error("tick without enable or edge");

endmodule

`default_nettype wire

// >>> core/drci_top.sv
// Row control interface of the multiply block: control selection, bank
// registers, operand routing and neighbour outputs, with a register port.
// Assumes all pins synchronous to clk_in; the arithmetic sits outside.

`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Registers grouped in banks: 9-bit operand halves and 18-bit output banks.
// - Eighteen controls: four clocks, clears, enables, two signs, two add/sub, two zeroes.
// - Each sign, add/sub and zero control registerable with own clock and clear.
// - In split mode each 9-bit half gets its own control set.
// - Clocks from row clock or local line; clears likewise.
// - Each enable taken from the clock's row, gated at the interface.
// - Each row delivers an 18-bit operand chosen from its 30 local lines.
// - Results unsigned only when both sign flags are low.
// - Add/sub select 0 upper adders, 1 lower; high adds, low subtracts.
// - Zero control 0 upper, 1 lower; high clears accumulator feedback.
// - Local lines: ten right, ten left, ten fed back from the block.
// - Each row drives nine outputs right, nine left, all eighteen to routing.
// - Each row hands 18 data bits plus its controls to the block.
// - Sign flags shared by every operand of the block unless split, when each 9-bit half has its own.
module drci_top (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [drci_pkg::AW-1:0] addr_in,
    input wire logic [drci_pkg::DW-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [drci_pkg::DW-1:0] rdata_out,
    input wire logic [drci_pkg::NROW-1:0] row_clk_in,
    input wire logic [drci_pkg::NROW-1:0][drci_pkg::NDL-1:0] dl_left_in,
    input wire logic [drci_pkg::NROW-1:0][drci_pkg::NDL-1:0] dl_right_in,
    input wire logic [drci_pkg::NROW-1:0][drci_pkg::WDAT-1:0] blk_data_in,
    output logic [drci_pkg::NROW-1:0][drci_pkg::WDAT-1:0] operand_out,
    output logic [drci_pkg::NHALF-1:0][drci_pkg::NCTL-1:0] half_ctl_out,
    output logic [drci_pkg::NHALF-1:0] result_signed_out,
    output logic [drci_pkg::NCLK-1:0] bank_tick_out,
    output logic [drci_pkg::NCLK-1:0] bank_clr_out,
    output logic [drci_pkg::NROW-1:0][drci_pkg::WHALF-1:0] dl_right_out,
    output logic [drci_pkg::NROW-1:0][drci_pkg::WHALF-1:0] dl_left_out,
    output logic [drci_pkg::NROW-1:0][drci_pkg::WDAT-1:0] route_out
);
    import drci_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [DW-1:0] cfg_q [NREG];
    logic [DW-1:0] cfg_d [NREG];
    logic [DW-1:0] rdata_q;
    logic [DW-1:0] rdata_d;
    logic [DW-1:0] status;
    logic [NHALF-1:0] signed_q;
    logic [NHALF-1:0] signed_d;
    logic [NCLK-1:0] tick_q;
    logic [NCLK-1:0] clrq_q;
    logic [NCLK-1:0] tick;
    logic [NCLK-1:0] clk_lvl;
    logic [NCLK-1:0] clr_lvl;
    logic [NROW-1:0][NLOC-1:0] loc;
    logic [NROW-1:0][WDAT-1:0] opnd_raw;
    logic [NROW-1:0][WDAT-1:0] out_q;
    logic [NHALF*NCTL-1:0] ctl_q;
    logic split;
    logic [5:0] widx;
    logic waligned;

    function automatic logic pick(input logic [NLOC-1:0] v, input logic [IW-1:0] i);
        pick = (int'(i) < NLOC) ? v[i] : 1'b0;
    endfunction

    function automatic logic [DW-1:0] wmask(input int i);
        if (i < int'(REG_ENA)) begin
            wmask = MASK_CLK;
        end else if (i < int'(REG_CTL)) begin
            wmask = MASK_ENA;
        end else if (i < int'(REG_ROW)) begin
            wmask = MASK_CTL;
        end else if (i < int'(REG_MODE)) begin
            wmask = MASK_ROW;
        end else begin
            wmask = MASK_MODE;
        end
    endfunction

    assign split = cfg_q[REG_MODE][F_SPLIT];
    assign widx = addr_in[7:2];
    assign waligned = (addr_in[1:0] == 2'b00);

    // ****************************************************************
    // Register port
    // ****************************************************************
    always_comb begin
        status = '0;
        status[NCTL-1:0] = ctl_q[NCTL-1:0];
        status[11:8] = clr_lvl;
        status[15:12] = clk_lvl;
        status[16] = split;
        status[18:17] = signed_q;
        for (int i = 0; i < NREG; i++) begin
            cfg_d[i] = cfg_q[i];
        end
        if (wr_in && waligned && (int'(widx) < NREG)) begin
            cfg_d[widx] = wdata_in & wmask(int'(widx));
        end
        rdata_d = '0;
        if (rd_in && waligned) begin
            if (int'(widx) < NREG) begin
                rdata_d = cfg_q[widx];
            end else if (widx == REG_STATUS) begin
                rdata_d = status;
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < NREG; i++) begin
                cfg_q[i] <= CFG_RST;
            end
            rdata_q <= '0;
        end else begin
            for (int i = 0; i < NREG; i++) begin
                cfg_q[i] <= cfg_d[i];
            end
            rdata_q <= rdata_d;
        end
    end

    assign rdata_out = rdata_q;

    // ****************************************************************
    // Local lines per row
    // ****************************************************************
    // Feedback taken from the registered block outputs to avoid a loop
    always_comb begin
        for (int r = 0; r < NROW; r++) begin
            loc[r] = {out_q[r][NDL-1:0], dl_right_in[r], dl_left_in[r]};
        end
    end

    // ****************************************************************
    // Clocks, enables and clears
    // ****************************************************************
    for (genvar k = 0; k < NCLK; k++) begin : g_clk
        drci_clkgen u_clkgen (
            .clk_in(clk_in),
            .nrst_in(nrst_in),
            .row_clk_in(row_clk_in[CLK_ROW[k]]),
            .local_in(pick(loc[CLK_ROW[k]], cfg_q[int'(REG_CLK) + k][F_IDX +: IW])),
            .src_in(cfg_q[int'(REG_CLK) + k][F_SRC]),
            .ena_in(pick(loc[CLK_ROW[k]], cfg_q[int'(REG_ENA) + k][F_IDX +: IW])),
            .level_out(clk_lvl[k]),
            .tick_out(tick[k])
        );
        // Clear sources are levels; no edge is needed
        assign clr_lvl[k] = cfg_q[int'(REG_CLR) + k][F_SRC] ? row_clk_in[CLR_ROW[k]] :
            pick(loc[CLR_ROW[k]], cfg_q[int'(REG_CLR) + k][F_IDX +: IW]);
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tick_q <= '0;
            clrq_q <= '0;
        end else begin
            tick_q <= tick;
            clrq_q <= clr_lvl;
        end
    end

    assign bank_tick_out = tick_q;
    assign bank_clr_out = clrq_q;

    // ****************************************************************
    // Dynamic controls, one bank each
    // ****************************************************************
    // Without split the lower set mirrors the upper configuration
    for (genvar j = 0; j < NHALF * NCTL; j++) begin : g_ctl
        logic [DW-1:0] c;
        assign c = (j >= NCTL && !split) ? cfg_q[int'(REG_CTL) + (j % NCTL)] :
            cfg_q[int'(REG_CTL) + j];
        drci_bank #(.W(1)) u_ctl (
            .clk_in(clk_in),
            .nrst_in(nrst_in),
            .d_in(pick(loc[CTL_ROW[j % NCTL]], c[F_IDX +: IW])),
            .tick_in(tick[c[F_CKS +: 2]]),
            .clr_in(clr_lvl[c[F_CRS +: 2]]),
            .bypass_in(!c[F_REG]),
            .q_out(ctl_q[j])
        );
    end

    // Add/sub and zero controls reach the upper and lower adders in order
    assign half_ctl_out = ctl_q;

    // ****************************************************************
    // Signed result flag
    // ****************************************************************
    always_comb begin
        for (int h = 0; h < NHALF; h++) begin
            signed_d[h] = ctl_q[h * NCTL + CTL_SIGN_A]
                | ctl_q[h * NCTL + CTL_SIGN_B];
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            signed_q <= '0;
        end else begin
            signed_q <= signed_d;
        end
    end

    assign result_signed_out = signed_q;

    // ****************************************************************
    // Operand selection and input banks
    // ****************************************************************
    // A rotating window stands in for a full crossbar to keep config small
    always_comb begin
        int base;
        int k;
        base = 0;
        k = 0;
        for (int r = 0; r < NROW; r++) begin
            base = int'(cfg_q[int'(REG_ROW) + r][F_IDX +: IW]);
            if (base >= NLOC) begin
                base = 0;
            end
            for (int i = 0; i < WDAT; i++) begin
                k = base + i;
                if (k >= NLOC) begin
                    k = k - NLOC;
                end
                opnd_raw[r][i] = loc[r][k];
            end
        end
    end

    for (genvar r = 0; r < NROW; r++) begin : g_row
        logic [DW-1:0] rc;
        logic [1:0] lo_cks;
        logic [1:0] lo_crs;
        assign rc = cfg_q[int'(REG_ROW) + r];
        assign lo_cks = split ? rc[F_LO_CKS +: 2] : rc[F_CKS +: 2];
        assign lo_crs = split ? rc[F_LO_CRS +: 2] : rc[F_CRS +: 2];
        drci_bank #(.W(WHALF)) u_hi (
            .clk_in(clk_in),
            .nrst_in(nrst_in),
            .d_in(opnd_raw[r][WDAT-1:WHALF]),
            .tick_in(tick[rc[F_CKS +: 2]]),
            .clr_in(clr_lvl[rc[F_CRS +: 2]]),
            .bypass_in(!rc[F_ROW_REG]),
            .q_out(operand_out[r][WDAT-1:WHALF])
        );
        drci_bank #(.W(WHALF)) u_lo (
            .clk_in(clk_in),
            .nrst_in(nrst_in),
            .d_in(opnd_raw[r][WHALF-1:0]),
            .tick_in(tick[lo_cks]),
            .clr_in(clr_lvl[lo_crs]),
            .bypass_in(!rc[F_ROW_REG]),
            .q_out(operand_out[r][WHALF-1:0])
        );
        drci_bank #(.W(WDAT)) u_out (
            .clk_in(clk_in),
            .nrst_in(nrst_in),
            .d_in(blk_data_in[r]),
            .tick_in(tick[rc[F_OUT_CKS +: 2]]),
            .clr_in(clr_lvl[rc[F_OUT_CRS +: 2]]),
            .bypass_in(!rc[F_OUT_REG]),
            .q_out(out_q[r])
        );
        assign dl_right_out[r] = out_q[r][WHALF-1:0];
        assign dl_left_out[r] = out_q[r][WDAT-1:WHALF];
        assign route_out[r] = out_q[r];
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_result_signed: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ##1 (result_signed_out[0] == ($past(half_ctl_out[0][CTL_SIGN_A])
            || $past(half_ctl_out[0][CTL_SIGN_B]))))
        else $error("signed flag wrong");
    a_sign_a_row: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!cfg_q[REG_CTL][F_REG] && $stable(cfg_q[REG_CTL]))
            |=> (half_ctl_out[0][CTL_SIGN_A] == $past(pick(loc[0], cfg_q[REG_CTL][4:0]))))
        else $error("sign A not from row 1");
    a_operand_pass: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!cfg_q[REG_ROW][F_ROW_REG] && $stable(cfg_q[REG_ROW]))
            |=> (operand_out[0] == $past(opnd_raw[0])))
        else $error("operand not routed");
    a_neighbour_split: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !cfg_q[int'(REG_ROW) + 1][F_OUT_REG]
            |=> ((route_out[1] == $past(blk_data_in[1]))
            && ({dl_left_out[1], dl_right_out[1]} == $past(blk_data_in[1]))))
        else $error("neighbour outputs differ from routing");
    a_read_once: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !$past(rd_in) |-> (rdata_out == '0))
        else $error("read data outside its cycle");
    a_tick_registered: assert property (@(posedge clk_in) disable iff (!nrst_in)
        tick[0] |=> bank_tick_out[0])
        else $error("bank tick lost");

    c_split_mode: cover property (@(posedge clk_in) disable iff (!nrst_in)
        split && tick[1]);
    c_signed_result: cover property (@(posedge clk_in) disable iff (!nrst_in)
        result_signed_out[0] ##1 !result_signed_out[0]);
    c_bank_clear: cover property (@(posedge clk_in) disable iff (!nrst_in)
        clr_lvl[2] && cfg_q[REG_ROW][F_ROW_REG]);
    c_status_read: cover property (@(posedge clk_in) disable iff (!nrst_in)
        rd_in && (widx == REG_STATUS));

endmodule

`default_nettype wire

// >>> verification/drci_cluster_model.sv
// Model of the logic-array clusters beside the multiply block rows.
// Assumes the bench sets wanted levels; the model launches them on clk_in.
`timescale 1ns/1ps
`default_nettype none
module drci_cluster_model (
    input wire logic clk_in,
    input wire logic [drci_pkg::NROW-1:0] rclk_in,
    input wire logic [drci_pkg::NROW-1:0][drci_pkg::NDL-1:0] left_in,
    input wire logic [drci_pkg::NROW-1:0][drci_pkg::NDL-1:0] right_in,
    input wire logic [drci_pkg::NROW-1:0][drci_pkg::WDAT-1:0] blk_in,
    output logic [drci_pkg::NROW-1:0] row_clk_out,
    output logic [drci_pkg::NROW-1:0][drci_pkg::NDL-1:0] dl_left_out,
    output logic [drci_pkg::NROW-1:0][drci_pkg::NDL-1:0] dl_right_out,
    output logic [drci_pkg::NROW-1:0][drci_pkg::WDAT-1:0] blk_data_out
);
    import drci_pkg::*;
    initial begin
        row_clk_out = '0;
        dl_left_out = '0;
        dl_right_out = '0;
        blk_data_out = '0;
    end
    // Controls and clocks may share a row; levels stay driven, never released
    always @(posedge clk_in) begin
        row_clk_out <= rclk_in;
        dl_left_out <= left_in;
        dl_right_out <= right_in;
        blk_data_out <= blk_in;
    end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the row control interface.
// Assumes the cluster model in front of the row pins and the register port.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import drci_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] x;} drci_row_t;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [AW-1:0] addr_in = '0;
    logic [DW-1:0] wdata_in = '0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [DW-1:0] rdata_out, d;
    logic [NROW-1:0] rclk = '0, row_clk_in;
    logic [NROW-1:0][NDL-1:0] lft = '0, rgt = '0, v, dl_left_in, dl_right_in;
    logic [NROW-1:0][WDAT-1:0] blk = '0, blk_data_in, operand_out, route_out;
    logic [NHALF-1:0][NCTL-1:0] half_ctl_out;
    logic [NHALF-1:0] result_signed_out;
    logic [NCLK-1:0] bank_tick_out, bank_clr_out;
    logic [NROW-1:0][WHALF-1:0] dl_right_out, dl_left_out;
    logic [NCTL-1:0] x;
    int n_fail = 0;
    int tests_run = 0;
    int k;
    drci_row_t rows [9] = '{'{8'h00, 32'hFFFFFFFF, 32'h0000011F},
        '{8'h10, 32'hFFFFFFFF, 32'h0000011F}, '{8'h20, 32'hFFFFFFFF, 32'h0000001F},
        '{8'h30, 32'hFFFFFFFF, 32'h0003311F}, '{8'h5C, 32'hFFFFFFFF, 32'h0003311F},
        '{8'h60, 32'hFFFFFFFF, 32'hF333331F}, '{8'h80, 32'hFFFFFFFF, 32'h00000001},
        '{8'h88, 32'hFFFFFFFF, 32'h00000000}, '{8'h01, 32'hFFFFFFFF, 32'h00000000}};
    always #4 clk_in = ~clk_in;
    drci_cluster_model i_model (.clk_in, .rclk_in(rclk), .left_in(lft), .right_in(rgt),
        .blk_in(blk), .row_clk_out(row_clk_in), .dl_left_out(dl_left_in),
        .dl_right_out(dl_right_in), .blk_data_out(blk_data_in));
    drci_top i_dut (.clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .row_clk_in, .dl_left_in, .dl_right_in, .blk_data_in, .operand_out, .half_ctl_out,
        .result_signed_out, .bank_tick_out, .bank_clr_out, .dl_right_out, .dl_left_out,
        .route_out);
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t register read %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_pin(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t pin value %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= w;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    task automatic settle;
        repeat (4) @(posedge clk_in);
        #1;
    endtask
    task automatic rst_dut;
        @(posedge clk_in);
        nrst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
        chk_pin(route_out[0], 32'h0);
        chk_pin(half_ctl_out, 32'h0);
        chk_pin({bank_tick_out, bank_clr_out, result_signed_out}, 32'h0);
        chk_pin(operand_out[0], 32'h0);
        @(posedge clk_in);
        nrst_in <= 1'b1;
    endtask
    // Rising row clock every four cycles on row 3; ticks counted one per cycle
    task automatic pulses(input int n);
        k = 0;
        for (int i = 0; i < 4 * n + 4; i++) begin
            @(posedge clk_in);
            rclk[2] <= (i < 4 * n) && !i[1];
            #1 k += bank_tick_out[0];
        end
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        #100000;
        n_fail++;
        print_verdict();
    end
    initial begin
        rst_dut();
        for (int a = 0; a <= 8'h84; a += 4) begin
            rd(8'(a));
            chk_reg(d, 32'h0);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a);
            chk_reg(d, rows[i].x);
        end
        rst_dut();
        @(posedge clk_in);
        for (int r = 0; r < NROW; r++) begin
            lft[r] <= 10'h2A5 ^ 10'(r);
            rgt[r] <= 10'h15A ^ 10'(r);
            blk[r] <= 18'h2B3C5 ^ 18'(r);
        end
        settle();
        for (int r = 0; r < NROW; r++) begin
            chk_pin(operand_out[r], {rgt[r][7:0], lft[r]});
            chk_pin(route_out[r], blk[r]);
            chk_pin({dl_left_out[r], dl_right_out[r]}, blk[r]);
        end
        // Base 20 wraps from the fed-back output bank into the left lines
        wr(8'h60, 32'h14);
        settle();
        chk_pin(operand_out[0], {lft[0][7:0], blk[0][9:0]});
        for (int c = 0; c < NCTL; c++) begin
            v = '0;
            v[CTL_ROW[c]][0] = 1'b1;
            for (int j = 0; j < NCTL; j++) x[j] = (CTL_ROW[j] == CTL_ROW[c]);
            @(posedge clk_in);
            lft <= v;
            settle();
            chk_pin(half_ctl_out[0], x);
            chk_pin(half_ctl_out[1], x);
            chk_pin(result_signed_out, {2{x[0] | x[1]}});
        end
        // Sign A registered on clock 0 (row 3 clock) with clear 0 on row 1 clock
        wr(8'h00, 32'h100);
        wr(8'h20, 32'h1);
        wr(8'h10, 32'h100);
        wr(8'h30, 32'h100);
        v = '0;
        v[0][0] = 1'b1;
        v[2][1] = 1'b1;
        @(posedge clk_in);
        lft <= v;
        settle();
        chk_pin(half_ctl_out[0][0], 1'b0);
        pulses(3);
        chk_pin(k, 3);
        chk_pin(half_ctl_out[0][0], 1'b1);
        @(posedge clk_in);
        lft <= '0;
        pulses(2);
        chk_pin(k, 0);
        chk_pin(half_ctl_out[0][0], 1'b1);
        @(posedge clk_in);
        rclk[0] <= 1'b1;
        settle();
        chk_pin(bank_clr_out[0], 1'b1);
        chk_pin(half_ctl_out[0][0], 1'b0);
        rst_dut();
        rclk <= '0;
        wr(8'h80, 32'h1);
        wr(8'h48, 32'h2);
        @(posedge clk_in);
        lft[0] <= 10'h004;
        settle();
        chk_pin({half_ctl_out[1][0], half_ctl_out[0][0]}, 2'b10);
        chk_pin(result_signed_out, 2'b10);
        print_verdict();
    end
endmodule
`default_nettype wire
